// File: design/esb_pkg.sv
// shared constants and carrier types for the external slave bus port
package esb_pkg;
    localparam int          CLK_MHZ        = 100;
    localparam int          BUS_MAX_MHZ    = 80;
    localparam int          BUS_MIN_PER_PS = 12500;
    localparam int          SYS_PER_PS     = 1000000 / CLK_MHZ;
    // least period rounds up to whole system cycles, then to an even divide
    localparam int          DIV_RAW        = (BUS_MIN_PER_PS + SYS_PER_PS - 1) / SYS_PER_PS;
    localparam int          DIV_HALF       = (DIV_RAW + 1) / 2;
    localparam logic [3:0]  HALF_CNT       = 4'(DIV_HALF);
    localparam int          NUM_CS         = 6;
    localparam int          ADDR_W         = 24;
    localparam int          DATA_W         = 32;
    localparam int          LANES          = 4;
    localparam logic [1:0]  WID_8          = 2'h0;
    localparam logic [1:0]  WID_16         = 2'h1;
    localparam logic [1:0]  WID_32         = 2'h2;
    localparam logic [2:0]  BOOT_CS        = 3'h0;
    localparam logic [3:0]  LANES_ALL      = 4'hf;
    localparam logic [3:0]  LANES_0        = 4'h1;
    localparam logic [3:0]  LANES_01       = 4'h3;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [2:0]  cs;
        logic        rd;
        logic [3:0]  lanes;
    } esb_req_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [31:0] dout;
        logic        doe;
        logic [5:0]  cs_n;
        logic        rnw;
        logic        ts;
        logic [3:0]  lane_en;
        logic        oe_n;
    } esb_pins_t;

    typedef enum logic [1:0] { ST_IDLE, ST_ADDR, ST_DATA, ST_HOLD } esb_state_t;
endpackage

// File: design/esb_port.sv
// external slave bus master port: pins, clock divider and transfer sequencer
module esb_port
    import esb_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire esb_req_t          req,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    input  wire logic [NUM_CS-1:0] cs_to_sdram,
    input  wire logic [1:0]        boot_width,
    input  wire logic [1:0]        hold_ext,
    input  wire logic              sample_fall,
    input  wire logic              sdram_req,
    output logic                   sdram_grant,
    output logic                   bus_clock_out,
    output logic                   sdram_clock_out,
    output esb_pins_t              pins,
    input  wire logic [DATA_W-1:0] din,
    input  wire logic              transfer_ack_n
);
    // divider state
    logic [3:0]  div_q, div_d;
    logic        bclk_q, bclk_d;
    logic        rise, fall;

    // divider: half period rounded up keeps the bus clock at or below its limit
    always_comb begin
        div_d  = div_q + 4'h1;
        bclk_d = bclk_q;
        if (div_q == HALF_CNT - 4'h1) begin
            div_d  = 4'h0;
            bclk_d = ~bclk_q;
        end
    end
    assign rise = (div_q == HALF_CNT - 4'h1) && !bclk_q;
    assign fall = (div_q == HALF_CNT - 4'h1) && bclk_q;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            div_q  <= 4'h0;
            bclk_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            bclk_q <= bclk_d;
        end
    end
    assign bus_clock_out   = bclk_q;
    assign sdram_clock_out = bclk_q;

    // pin inputs pass three flops; a change counts once stages two and three agree
    logic [DATA_W:0] s1_q, s2_q, s3_q, in_q, in_d;
    always_comb begin
        in_d = in_q;
        if (s2_q == s3_q) in_d = s3_q;
    end
    always_ff @(posedge clock) begin
        if (!nrst) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            in_q <= '1;
        end else begin
            s1_q <= {transfer_ack_n, din};
            s2_q <= s1_q;
            s3_q <= s2_q;
            in_q <= in_d;
        end
    end
    logic ack_now;
    logic smp;
    assign ack_now = !in_q[DATA_W];
    assign smp     = sample_fall ? fall : rise;

    // sequencer state
    esb_state_t  st_q, st_d;
    esb_req_t    r_q, r_d;
    esb_pins_t   p_q, p_d;
    logic [1:0]  hold_q, hold_d;
    logic        own_q, own_d;
    logic        rv_q, rv_d;
    logic        got_q, got_d; // ack caught on a falling edge, waiting for the next rise
    logic [31:0] rd_q, rd_d;
    logic [3:0]  lanes;

    // boot select width narrows the lanes it uses
    always_comb begin
        lanes = req.lanes;
        if (req.cs == BOOT_CS) begin
            case (boot_width)
                WID_8:   lanes = req.lanes & LANES_0;
                WID_16:  lanes = req.lanes & LANES_01;
                default: lanes = req.lanes & LANES_ALL;
            endcase
        end
    end

    assign req_ready   = (st_q == ST_IDLE) && rise && !sdram_req && !cs_to_sdram[req.cs];
    assign sdram_grant = !own_q;

    // transfer sequencer; outputs only move on bus clock edges
    always_comb begin
        st_d   = st_q;
        r_d    = r_q;
        p_d    = p_q;
        hold_d = hold_q;
        own_d  = own_q;
        rv_d   = 1'b0;
        rd_d   = rd_q;
        got_d  = got_q;
        case (st_q)
            ST_IDLE: begin
                own_d = 1'b0;
                if (req_valid && req_ready) begin
                    r_d           = req;
                    r_d.lanes     = lanes;
                    own_d         = 1'b1;
                    p_d.addr      = req.addr[ADDR_W-1:0];
                    p_d.dout      = req.addr;
                    p_d.doe       = 1'b1;
                    p_d.cs_n      = '1;
                    p_d.cs_n[req.cs] = 1'b0;
                    p_d.rnw       = req.rd;
                    p_d.ts        = 1'b1;
                    p_d.lane_en   = 4'h0;
                    p_d.oe_n      = 1'b1;
                    st_d          = ST_ADDR;
                end
            end
            ST_ADDR: if (rise) begin
                p_d.ts      = 1'b0;
                p_d.dout    = r_q.wdata;
                p_d.doe     = !r_q.rd;
                p_d.lane_en = r_q.lanes;
                p_d.oe_n    = !r_q.rd;
                st_d        = ST_DATA;
            end
            ST_DATA: begin
                // inputs may be taken on the fall, but pins still only move on a rise
                if (smp && ack_now) begin
                    rd_d  = in_q[DATA_W-1:0];
                    got_d = 1'b1;
                end
                if (rise && (got_q || (smp && ack_now))) begin
                    got_d       = 1'b0;
                    rv_d        = 1'b1;
                    p_d.cs_n    = '1;
                    p_d.oe_n    = 1'b1;
                    p_d.lane_en = 4'h0;
                    p_d.doe     = 1'b0;
                    hold_d      = hold_ext;
                    st_d        = ST_HOLD;
                end
            end
            ST_HOLD: if (rise) begin
                // address kept for the extra cycles, then released
                if (hold_q == 2'h0) begin
                    own_d = 1'b0;
                    st_d  = ST_IDLE;
                end else begin
                    hold_d = hold_q - 2'h1;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_q   <= ST_IDLE;
            r_q    <= '0;
            p_q    <= '{addr: '0, dout: '0, doe: 1'b0, cs_n: '1, rnw: 1'b1,
                        ts: 1'b0, lane_en: 4'h0, oe_n: 1'b1};
            hold_q <= 2'h0;
            own_q  <= 1'b0;
            rv_q   <= 1'b0;
            rd_q   <= '0;
            got_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            r_q    <= r_d;
            p_q    <= p_d;
            hold_q <= hold_d;
            own_q  <= own_d;
            rv_q   <= rv_d;
            rd_q   <= rd_d;
            got_q  <= got_d;
        end
    end

    assign pins      = p_q;
    assign rsp_valid = rv_q;
    assign rsp_rdata = rd_q;
endmodule // esb_port

// File: test/esb_port_properties.sv
// checker of the external slave bus port pin sequencing
module esb_chk
    import esb_pkg::*;
(
    input wire logic              clock,
    input wire logic              nrst,
    input wire logic              req_ready,
    input wire esb_req_t          req,
    input wire logic              rsp_valid,
    input wire logic [NUM_CS-1:0] cs_to_sdram,
    input wire logic              sdram_req,
    input wire logic              sdram_grant,
    input wire logic              bus_clock_out,
    input wire logic              sdram_clock_out,
    input wire esb_pins_t         pins,
    input wire logic              transfer_ack_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    chk_start_pulse: assert property ($rose(pins.ts) |=> pins.ts ##1 !pins.ts)
        else $error("start pulse width wrong");
    chk_start_select: assert property (pins.ts |-> pins.cs_n != 6'h3f)
        else $error("start without select");
    chk_addr_data: assert property (pins.ts |-> pins.doe && pins.dout[23:0] == pins.addr)
        else $error("address missing on data lines");
    chk_pins_rise: assert property ($changed(pins) |-> $rose(bus_clock_out))
        else $error("pins moved off the bus clock rise");
    chk_bus_rate: assert property ($rose(bus_clock_out) |=> !$rose(bus_clock_out))
        else $error("bus clock too fast");
    chk_same_rate: assert property (bus_clock_out == sdram_clock_out)
        else $error("bus and sdram clocks differ");
    chk_grant_free: assert property (sdram_grant |-> pins.cs_n == 6'h3f)
        else $error("pins granted while a select is low");
    chk_ready_ok: assert property (req_ready |-> !sdram_req && !cs_to_sdram[req.cs])
        else $error("request taken while refused");
    chk_ack_ends: assert property (rsp_valid |-> ##[0:2] (pins.cs_n == 6'h3f && pins.oe_n))
        else $error("cycle not ended after ack");
    chk_ack_seen: assert property (rsp_valid |-> !$past(transfer_ack_n, 3))
        else $error("response without ack");
    cover property (rsp_valid && pins.rnw);
    cover property (rsp_valid && !pins.rnw);
    cover property (sdram_req && sdram_grant);
endmodule // esb_chk

bind esb_port esb_chk u_esb_chk (.clock(clock), .nrst(nrst), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .cs_to_sdram(cs_to_sdram), .sdram_req(sdram_req),
    .sdram_grant(sdram_grant), .bus_clock_out(bus_clock_out),
    .sdram_clock_out(sdram_clock_out), .pins(pins), .transfer_ack_n(transfer_ack_n));

// File: test/esb_slave_model.sv
// behavioural slave: waits, then acks until its select drops
module esb_slave_model
    import esb_pkg::*;
(
    input wire logic        bus_clock_out,
    input wire esb_pins_t   pins,
    input wire logic [3:0]  wait_bc,
    input wire logic [31:0] rdata,
    output logic [31:0]     din,
    output logic            transfer_ack_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt;
    initial {cnt, din, transfer_ack_n} = {36'h0, 1'b1};
    // idle data lines toggle so stale data never passes for a read
    always @(posedge bus_clock_out) begin
        din <= ~din;
        if (pins.cs_n == 6'h3f) begin
            cnt <= 4'h0;
            transfer_ack_n <= 1'b1;
        end else if (cnt < wait_bc) begin
            cnt <= cnt + 4'h1;
        end else begin
            transfer_ack_n <= 1'b0;
            if (pins.rnw) din <= rdata;
        end
    end
endmodule // esb_slave_model

// File: test/test_esb_port.sv
// self-checking bench of the external slave bus port
module test_esb_port
    import esb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock = 0, nrst = 0, req_valid = 0, sample_fall = 0, sdram_req = 0;
    logic        req_ready, rsp_valid, sdram_grant, bus_clock_out, sdram_clock_out, ack_n;
    esb_req_t    req = '0;
    esb_pins_t   pins;
    logic [5:0]  cs_to_sdram = 6'h0;
    logic [1:0]  boot_width = WID_32, hold_ext = 2'h0;
    logic [31:0] rsp_rdata, din, ts_data, rdata = 32'h0;
    logic [3:0]  wait_bc = 4'h0, lane_seen = 4'h0;
    logic [31:0] data_seen = 32'h0;
    int          failures = 0, check_count = 0;
    always #5 clock = ~clock;
    // remember what the data lines carried during the start pulse
    always @(negedge clock) if (pins.ts === 1'b1) ts_data = pins.dout;
    // lanes and data lines as they stand in the data phase
    always @(negedge clock) if (pins.cs_n !== 6'h3f && pins.ts === 1'b0) begin
        lane_seen = pins.lane_en;
        data_seen = pins.dout;
    end
    esb_port u_esb_port (.clock(clock), .nrst(nrst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .cs_to_sdram(cs_to_sdram), .boot_width(boot_width), .hold_ext(hold_ext),
        .sample_fall(sample_fall), .sdram_req(sdram_req), .sdram_grant(sdram_grant),
        .bus_clock_out(bus_clock_out), .sdram_clock_out(sdram_clock_out), .pins(pins),
        .din(din), .transfer_ack_n(ack_n));
    esb_slave_model u_esb_slave_model (.bus_clock_out(bus_clock_out), .pins(pins),
        .wait_bc(wait_bc), .rdata(rdata), .din(din), .transfer_ack_n(ack_n));
    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        if (failures == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one whole transfer; request held until taken, then bounded wait for the end
    task xfer(input logic [31:0] a, w, input logic [2:0] cs, input logic rd, input logic [31:0] exp);
        int n;
        @(posedge clock);
        #1 req = '{addr: a, wdata: w, cs: cs, rd: rd, lanes: LANES_ALL};
        req_valid = 1;
        rdata = exp;
        ts_data = 32'h0;
        n = 0;
        do begin @(negedge clock); n++; end while (req_ready !== 1'b1 && n < 100);
        @(posedge clock);
        #1 req_valid = 0;
        n = 0;
        do begin @(negedge clock); n++; end while (rsp_valid !== 1'b1 && n < 200);
        check(32'(rsp_valid), 32'h1);
        check(ts_data, a);
        if (rd) check(rsp_rdata, exp);
        if (!rd) check(data_seen, w);
        if (cs != BOOT_CS) check(32'(lane_seen), 32'(LANES_ALL));
        // settings that follow are changed just after a rise, like all stimulus
        @(posedge clock);
        #1;
    endtask
    // a request that must never be taken
    task refused(input logic [2:0] cs);
        int seen;
        seen = 0;
        @(posedge clock);
        #1 req.cs = cs;
        req_valid = 1;
        repeat (10) begin @(negedge clock); seen += (req_ready === 1'b1); end
        @(posedge clock);
        #1 req_valid = 0;
        check(32'(seen), 32'h0);
    endtask
    initial begin
        repeat (5) @(posedge clock);
        #1 nrst = 1;
        xfer(32'h0012_3456, 32'hcafe_f00d, 3'h2, 1'b0, 32'h0);
        xfer(32'h0000_0abc, 32'h0, 3'h2, 1'b1, 32'h5a5a_a5a5);
        wait_bc = 4'h5;
        xfer(32'h00ff_0010, 32'h0, 3'h5, 1'b1, 32'h1234_8765);
        hold_ext = 2'h3;
        sample_fall = 1;
        xfer(32'h0040_0020, 32'h0, 3'h3, 1'b1, 32'h0f0f_3c3c);
        xfer(32'h0040_0024, 32'h9876_5432, 3'h3, 1'b0, 32'h0);
        for (int i = 0; i < 3; i++) begin
            boot_width = 2'(i);
            xfer(32'h100 + 32'(i), 32'h0, BOOT_CS, 1'b1, 32'h0);
            check(32'(lane_seen), 32'(i == 0 ? LANES_0 : i == 1 ? LANES_01 : LANES_ALL));
        end
        sdram_req = 1;
        refused(3'h1);
        check(32'(sdram_grant), 32'h1);
        sdram_req = 0;
        cs_to_sdram = 6'h10;
        refused(3'h4);
        give_verdict;
    end
    // cut a hang short well past the expected run length
    initial begin
        #100000;
        failures++;
        give_verdict;
    end
endmodule // test_esb_port
